// ---- src/rpa_pkg.sv ----
package rpa_pkg;
	// Register offsets (byte addresses)
	localparam logic [11:0] RPA_OFS_PKT_FMT_A = 12'h0514;
	localparam logic [11:0] RPA_OFS_PKT_FMT_B = 12'h0518;
	localparam logic [11:0] RPA_OFS_BASE_ZERO = 12'h051c;
	localparam logic [11:0] RPA_OFS_BASE_ONE = 12'h0520;
	localparam logic [11:0] RPA_OFS_PREFIX_LOW = 12'h0524;
	localparam logic [11:0] RPA_OFS_PREFIX_HIGH = 12'h0528;
	localparam logic [11:0] RPA_OFS_TX_ADDR = 12'h052c;
	localparam logic [11:0] RPA_OFS_RX_ENABLE = 12'h0530;
	localparam logic [11:0] RPA_OFS_FRAME_IN = 12'h0540;
	localparam logic [11:0] RPA_OFS_FRAME_OUT = 12'h0544;
	// Field positions in packet_format_config_b
	localparam int RPA_MAX_PAYLOAD_LSB = 0;
	localparam int RPA_STATIC_EXTRA_LSB = 8;
	localparam int RPA_BASE_LEN_LSB = 16;
	localparam int RPA_ORDER_BIT = 24;
	localparam int RPA_WHITEN_BIT = 25;
	// Writable bits per register
	localparam logic [31:0] RPA_MASK_PKT_FMT_B = 32'h0307_ffff;
	localparam logic [31:0] RPA_MASK_PKT_FMT_A = 32'h0000_000f;
	localparam logic [31:0] RPA_MASK_TX_ADDR = 32'h0000_0007;
	localparam logic [31:0] RPA_MASK_RX_ENABLE = 32'h0000_00ff;
	localparam logic [31:0] RPA_MASK_FRAME_IN = 32'h0000_00ff;
	localparam logic [31:0] RPA_RESET_VALUE = 32'h0000_0000;
	// Legal base length range
	localparam logic [2:0] RPA_BASE_LEN_MIN = 3'h2;
	localparam logic [2:0] RPA_BASE_LEN_MAX = 3'h4;
	localparam logic [7:0] RPA_LENGTH_BITS_MAX = 8'h08;
endpackage

// ---- src/rpa_config.sv ----
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - Payload longer than max_payload_bytes is cut to that maximum.
// - Static length extra is added to the length field, transmit and receive; here only the frame_in_r length gets it, i_rx_length_field is unused.
// - Base address length is base_length_bytes, legal from two to four.
// - Address is base address followed by one prefix byte.
// - Bit order zero sends LSB first, one sends MSB first.
// - Bit order applies to header fields, length field and payload.
// - Whitening enable zero turns whitening off, one turns it on.
// - Base address zero is a 32-bit writable register, reset zero.
// - Base address one is a 32-bit writable register, reset zero.
// - Prefixes for logical addresses zero to three share one register.
// - Prefixes for logical addresses four to seven share one register.
// - Transmit logical address picks the base and prefix sent.
// - Each of eight logical addresses may be enabled for reception.
// - Length field width in bits comes from a separate config register.
module rpa_config
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [7:0] i_rx_length_field,
	input wire logic [7:0] i_rx_logical_addr,
	output logic [7:0] o_payload_bytes,
	output logic [8:0] o_total_bytes,
	output logic [2:0] o_address_bytes,
	output logic [39:0] o_tx_address,
	output logic [7:0] o_rx_enabled,
	output logic o_rx_accept,
	output logic o_msb_first,
	output logic o_whitening_on,
	output logic [3:0] o_length_field_bits,
	output logic o_base_length_illegal
);
	import rpa_pkg::*;

	logic [31:0] fmt_a_r, fmt_a_nxt;
	logic [31:0] fmt_b_r, fmt_b_nxt;
	logic [31:0] base_address_zero_r, base_address_zero_nxt;
	logic [31:0] base_address_one_r, base_address_one_nxt;
	logic [31:0] pfx_lo_r, pfx_lo_nxt;
	logic [31:0] pfx_hi_r, pfx_hi_nxt;
	logic [31:0] txa_r, txa_nxt;
	logic [31:0] rxen_r, rxen_nxt;
	logic [31:0] frame_in_r, frame_in_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [7:0] pay_r, pay_nxt;
	logic [8:0] tot_r, tot_nxt;
	logic [2:0] alen_r, alen_nxt;
	logic [39:0] txad_r, txad_nxt;
	logic acc_r, acc_nxt;
	logic [7:0] max_payload_bytes, static_length_extra, lenfield, masklen;
	logic [2:0] base_length_bytes;
	logic [2:0] tx_sel;
	logic [31:0] base_sel;
	logic [7:0] prefix_sel;
	logic [31:0] base_cut;

	// Field views of the format register and the transmit address register
	assign max_payload_bytes = fmt_b_r[RPA_MAX_PAYLOAD_LSB +: 8];
	assign static_length_extra = fmt_b_r[RPA_STATIC_EXTRA_LSB +: 8];
	assign base_length_bytes = fmt_b_r[RPA_BASE_LEN_LSB +: 3];
	assign tx_sel = txa_r[2:0];

	// Register writes; only writable bits are kept
	always_comb
	begin
		fmt_a_nxt = fmt_a_r;
		fmt_b_nxt = fmt_b_r;
		base_address_zero_nxt = base_address_zero_r;
		base_address_one_nxt = base_address_one_r;
		pfx_lo_nxt = pfx_lo_r;
		pfx_hi_nxt = pfx_hi_r;
		txa_nxt = txa_r;
		rxen_nxt = rxen_r;
		frame_in_nxt = frame_in_r;
		if (i_wr)
		begin
			case (i_addr)
				RPA_OFS_PKT_FMT_A: fmt_a_nxt = i_wdata & RPA_MASK_PKT_FMT_A;
				RPA_OFS_PKT_FMT_B: fmt_b_nxt = i_wdata & RPA_MASK_PKT_FMT_B;
				RPA_OFS_BASE_ZERO: base_address_zero_nxt = i_wdata;
				RPA_OFS_BASE_ONE: base_address_one_nxt = i_wdata;
				RPA_OFS_PREFIX_LOW: pfx_lo_nxt = i_wdata;
				RPA_OFS_PREFIX_HIGH: pfx_hi_nxt = i_wdata;
				RPA_OFS_TX_ADDR: txa_nxt = i_wdata & RPA_MASK_TX_ADDR;
				RPA_OFS_RX_ENABLE: rxen_nxt = i_wdata & RPA_MASK_RX_ENABLE;
				RPA_OFS_FRAME_IN: frame_in_nxt = i_wdata & RPA_MASK_FRAME_IN;
				default: ;
			endcase
		end
	end

	// Length arithmetic; length field masked to its configured width
	always_comb
	begin
		masklen = 8'hff;
		if (fmt_a_r[3:0] < 4'h8)
			masklen = 8'(({8'h00, 8'h01} << fmt_a_r[3:0]) - 16'h0001);
		lenfield = frame_in_r[7:0] & masklen;
		// Truncation applies to the length field, then static extra added
		pay_nxt = (lenfield > max_payload_bytes) ? max_payload_bytes
			: lenfield;
		tot_nxt = {1'b0, pay_nxt} + {1'b0, static_length_extra};
	end

	// Transmit address assembly and receive accept
	always_comb
	begin
		// Base zero only for logical address zero
		base_sel = (tx_sel == 3'h0) ? base_address_zero_r : base_address_one_r;
		prefix_sel = tx_sel[2] ? pfx_hi_r[{tx_sel[1:0], 3'h0} +: 8]
			: pfx_lo_r[{tx_sel[1:0], 3'h0} +: 8];
		// Unused low base bytes dropped; out-of-range lengths clamp
		alen_nxt = 3'h5;
		base_cut = base_sel;
		if (base_length_bytes <= RPA_BASE_LEN_MIN)
		begin
			alen_nxt = 3'h3;
			base_cut = {base_sel[31:16], 16'h0000};
		end
		else if (base_length_bytes == 3'h3)
		begin
			alen_nxt = 3'h4;
			base_cut = {base_sel[31:8], 8'h00};
		end
		// Prefix byte follows the base on air
		txad_nxt = {prefix_sel, base_cut};
		acc_nxt = rxen_r[i_rx_logical_addr[2:0]] &&
			(i_rx_logical_addr[7:3] == 5'h00);
	end

	// Read mux; unmapped reads return zero
	always_comb
	begin
		rdata_nxt = RPA_RESET_VALUE;
		if (i_rd)
		begin
			case (i_addr)
				RPA_OFS_PKT_FMT_A: rdata_nxt = fmt_a_r;
				RPA_OFS_PKT_FMT_B: rdata_nxt = fmt_b_r;
				RPA_OFS_BASE_ZERO: rdata_nxt = base_address_zero_r;
				RPA_OFS_BASE_ONE: rdata_nxt = base_address_one_r;
				RPA_OFS_PREFIX_LOW: rdata_nxt = pfx_lo_r;
				RPA_OFS_PREFIX_HIGH: rdata_nxt = pfx_hi_r;
				RPA_OFS_TX_ADDR: rdata_nxt = txa_r;
				RPA_OFS_RX_ENABLE: rdata_nxt = rxen_r;
				RPA_OFS_FRAME_IN: rdata_nxt = frame_in_r;
				RPA_OFS_FRAME_OUT: rdata_nxt = {23'h00_0000, tot_r};
				default: rdata_nxt = RPA_RESET_VALUE;
			endcase
		end
	end

	// State registers, all reset to zero except alen_r, which resets to three
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			fmt_a_r <= RPA_RESET_VALUE;
			fmt_b_r <= RPA_RESET_VALUE;
			base_address_zero_r <= RPA_RESET_VALUE;
			base_address_one_r <= RPA_RESET_VALUE;
			pfx_lo_r <= RPA_RESET_VALUE;
			pfx_hi_r <= RPA_RESET_VALUE;
			txa_r <= RPA_RESET_VALUE;
			rxen_r <= RPA_RESET_VALUE;
			frame_in_r <= RPA_RESET_VALUE;
			rdata_r <= RPA_RESET_VALUE;
			pay_r <= 8'h00;
			tot_r <= 9'h000;
			alen_r <= 3'h3;
			txad_r <= 40'h00_0000_0000;
			acc_r <= 1'b0;
		end
		else
		begin
			fmt_a_r <= fmt_a_nxt;
			fmt_b_r <= fmt_b_nxt;
			base_address_zero_r <= base_address_zero_nxt;
			base_address_one_r <= base_address_one_nxt;
			pfx_lo_r <= pfx_lo_nxt;
			pfx_hi_r <= pfx_hi_nxt;
			txa_r <= txa_nxt;
			rxen_r <= rxen_nxt;
			frame_in_r <= frame_in_nxt;
			rdata_r <= rdata_nxt;
			pay_r <= pay_nxt;
			tot_r <= tot_nxt;
			alen_r <= alen_nxt;
			txad_r <= txad_nxt;
			acc_r <= acc_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign o_rdata = rdata_r;
	assign o_payload_bytes = pay_r;
	assign o_total_bytes = tot_r;
	assign o_address_bytes = alen_r;
	assign o_tx_address = txad_r;
	assign o_rx_enabled = rxen_r[7:0];
	assign o_rx_accept = acc_r;
	assign o_msb_first = fmt_b_r[RPA_ORDER_BIT];
	assign o_whitening_on = fmt_b_r[RPA_WHITEN_BIT];
	assign o_length_field_bits = fmt_a_r[3:0];
	// Flag for software misuse, logic still clamps
	assign o_base_length_illegal = (base_length_bytes < RPA_BASE_LEN_MIN) ||
		(base_length_bytes > RPA_BASE_LEN_MAX);
endmodule

// ---- test/rpa_config_sva.sv ----
`timescale 1ns/1ps
module rpa_config_sva
import rpa_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic [7:0] i_rx_logical_addr,
	input wire logic [7:0] o_payload_bytes,
	input wire logic [8:0] o_total_bytes,
	input wire logic [2:0] o_address_bytes,
	input wire logic [7:0] o_rx_enabled,
	input wire logic o_rx_accept,
	input wire logic o_msb_first,
	input wire logic o_whitening_on
);
	logic [31:0] fb_r;
	logic [2:0] bl;
	logic fw;
	assign fw = i_wr && i_addr == RPA_OFS_PKT_FMT_B;
	assign bl = fb_r[18:16];
	// Shadow copy of the format register
	always_ff @(posedge i_mclk)
		fb_r <= i_reset ? '0 : fw ? i_wdata & RPA_MASK_PKT_FMT_B : fb_r;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	AST_MSB: assert property (fw |=> o_msb_first == $past(i_wdata[24]))
		else $error("bit order not taken");
	AST_WHT: assert property (fw |=> o_whitening_on == $past(i_wdata[25]))
		else $error("whitening not taken");
	AST_TRUNC: assert property (o_payload_bytes <= $past(fb_r[7:0]))
		else $error("payload above maximum");
	AST_TOTAL: assert property (!i_wr [*4] |->
		o_total_bytes == 9'(o_payload_bytes) + 9'(fb_r[15:8]))
		else $error("static extra not added");
	AST_ALEN: assert property (!i_wr [*2] |-> o_address_bytes ==
		(bl <= 3'h2 ? 3'h3 : bl == 3'h3 ? 3'h4 : 3'h5))
		else $error("address length wrong");
	AST_RDFMT: assert property (i_rd && i_addr == RPA_OFS_PKT_FMT_B |=>
		o_rdata == $past(fb_r)) else $error("format readback wrong");
	AST_RDIDLE: assert property (!$past(i_rd) |-> o_rdata == '0)
		else $error("read data outside its cycle");
	AST_ACCEPT: assert property (o_rx_accept == ($past(i_rx_logical_addr) < 8 &&
		$past(o_rx_enabled[i_rx_logical_addr[2:0]]))) else $error("accept wrong");
	cover property (o_msb_first && o_whitening_on);
	cover property (o_rx_accept);
	cover property (o_total_bytes > 9'(o_payload_bytes));
endmodule
bind rpa_config rpa_config_sva u_rpa_config_sva (.*);

// ---- test/rpa_remote_model.sv ----
`timescale 1ns/1ps
module rpa_remote_model
(
	input wire logic i_mclk,
	input wire logic i_reset,
	output logic [7:0] o_rx_logical_addr,
	output logic [7:0] o_rx_length_field
);
	// Peer sweeps all logical addresses and two that do not exist
	always @(posedge i_mclk)
		if (i_reset || o_rx_logical_addr == 8'h09)
			o_rx_logical_addr <= 8'h00;
		else
			o_rx_logical_addr <= o_rx_logical_addr + 8'h01;
	// Unused by the block, so it keeps changing
	assign o_rx_length_field = ~o_rx_logical_addr;
endmodule

// ---- test/tb_rpa_config.sv ----
`timescale 1ns/1ps
module tb_rpa_config;
	import rpa_pkg::*;
	logic i_mclk = 1'b0;
	logic i_reset = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [11:0] i_addr = 12'h0000;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic [31:0] o_rdata;
	logic [7:0] i_rx_length_field, i_rx_logical_addr, o_payload_bytes, o_rx_enabled;
	logic [8:0] o_total_bytes;
	logic [2:0] o_address_bytes;
	logic [39:0] o_tx_address;
	logic [3:0] o_length_field_bits;
	logic o_rx_accept, o_msb_first, o_whitening_on, o_base_length_illegal;
	int fail_count = 0;
	int checked = 0;
	always #12.5 i_mclk = ~i_mclk;
	rpa_config u_rpa_config (.*);
	rpa_remote_model u_rpa_remote_model (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.o_rx_logical_addr(i_rx_logical_addr),
		.o_rx_length_field(i_rx_length_field)
	);
	task chk(input logic [39:0] s, input logic [39:0] e);
		checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	// Strobe held for exactly one sampling edge
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		repeat (3) @(posedge i_mclk);
		#1;
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		chk(40'(o_rdata), 40'(e));
	endtask
	task results;
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge i_mclk);
		i_reset <= 1'b0;
		for (int k = 0; k < 6; k++) rdc(12'h0518 + 12'(4 * k), 32'h0);
		chk(40'(o_address_bytes), 40'h3);
		chk(40'(o_base_length_illegal), 40'h1);
		$display("reset test done");
		wr(RPA_OFS_BASE_ZERO, 32'h1122_3344);
		wr(RPA_OFS_BASE_ONE, 32'h5566_7788);
		wr(RPA_OFS_PREFIX_LOW, 32'ha3a2_a1a0);
		wr(RPA_OFS_PREFIX_HIGH, 32'ha7a6_a5a4);
		wr(RPA_OFS_PKT_FMT_B, 32'h8304_0510);
		chk(40'(o_base_length_illegal), 40'h0);
		rdc(RPA_OFS_PKT_FMT_B, 32'h0304_0510);
		rdc(RPA_OFS_BASE_ZERO, 32'h1122_3344);
		rdc(RPA_OFS_BASE_ONE, 32'h5566_7788);
		rdc(RPA_OFS_PREFIX_LOW, 32'ha3a2_a1a0);
		rdc(RPA_OFS_PREFIX_HIGH, 32'ha7a6_a5a4);
		chk(40'({o_msb_first, o_whitening_on}), 40'h3);
		chk(40'(o_address_bytes), 40'h5);
		for (int k = 0; k < 8; k++)
		begin
			wr(RPA_OFS_TX_ADDR, 32'hffff_fff8 | 32'(k));
			chk(o_tx_address, {8'ha0 + 8'(k), k == 0 ? 32'h1122_3344 : 32'h5566_7788});
		end
		wr(RPA_OFS_PKT_FMT_B, 32'h0002_0510);
		chk(o_tx_address, {8'ha7, 32'h5566_0000});
		chk(40'(o_address_bytes), 40'h3);
		$display("address test done");
		wr(RPA_OFS_PKT_FMT_A, 32'h0000_0008);
		wr(RPA_OFS_FRAME_IN, 32'h0000_0040);
		chk(40'({o_payload_bytes, o_total_bytes}), 40'({8'h10, 9'h015}));
		rdc(RPA_OFS_FRAME_OUT, 32'h0000_0015);
		wr(RPA_OFS_FRAME_IN, 32'h0000_000c);
		wr(RPA_OFS_PKT_FMT_B, 32'h0002_ffff);
		chk(40'({o_payload_bytes, o_total_bytes}), 40'({8'h0c, 9'h10b}));
		wr(RPA_OFS_RX_ENABLE, 32'hffff_ff25);
		chk(40'(o_rx_enabled), 40'h25);
		wr(RPA_OFS_PKT_FMT_A, 32'h0000_0005);
		chk(40'(o_length_field_bits), 40'h5);
		wr(RPA_OFS_FRAME_IN, 32'h0000_0040);
		chk(40'({o_payload_bytes, o_total_bytes}), 40'({8'h00, 9'h0ff}));
		rdc(12'h0600, 32'h0);
		$display("length test done");
		results;
	end
	// Tests need well under a thousand cycles
	initial
	begin
		repeat (3000) @(posedge i_mclk);
		fail_count++;
		results;
	end
endmodule
